// >>> hw/arx_clk_select.sv
// Purpose: Input selection and glitch-free master clock switching with APB registers
// Assumes: Clock pins are sampled as levels at clk_sys; select pins and receiver input lines pass through unsampled
// Notes:   External and recovered clock pins must run below half of clk_sys
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Unselected input lines are left floating
// - Software mode: decoder field selects input, resets zero
// - Software mode: separate pass-through field selects input
// - Pass-through is raw copy, never retimed
// - Hardware mode: pins reach only inputs zero-three
// - Hardware mode: pass-through pins pick copied input
// - Auto switch puts external clock out when unlocked
// - Clock changeover never produces runts or glitches
// - Hardware mode: external clock rising edge enables switching
// - Hardware switching enable clears only on reset
// - Software mode: auto enable bit enables switching
// - Software mode: force bit selects external clock
// - Master mode serial clocks follow switched clock
// - Unlocked switched: lr over 256, bit over 4
// - Switching disabled, force bit clear: clocks follow the idle oscillator
module arx_clk_select (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire arx_pkg::arx_apb_req_t apb_req,
	output arx_pkg::arx_apb_rsp_t      apb_rsp,
	input  wire logic                  hw_mode,
	input  wire logic [1:0]            decoder_input_select_pins,
	input  wire logic [1:0]            passthrough_select_pins,
	input  wire logic [7:0]            rx_input_lines,
	output logic      [7:0]            rx_line_bias_en,
	output logic                       shared_negative_bias_en,
	output logic                       decoder_data,
	output logic                       passthrough_out,
	input  wire logic                  external_system_clock,
	input  wire logic                  pll_oscillator,
	input  wire logic                  pll_locked,
	input  wire logic                  serial_master_mode,
	output logic                       recovered_master_clock,
	input  wire logic                  serial_bit_clock_i,
	output logic                       serial_bit_clock_o,
	output logic                       serial_bit_clock_oe,
	input  wire logic                  serial_lr_clock_i,
	output logic                       serial_lr_clock_o,
	output logic                       serial_lr_clock_oe
);
	import arx_pkg::*;

	arx_top_st_t st_r;
	arx_top_st_t st_nxt;
	logic [2:0]  dec_sel;
	logic [2:0]  pass_sel;
	logic        auto_en;
	logic        force_sw;
	logic        want_ext;
	logic        div_bclk;
	logic        div_lrck;
	logic        setup_ph;
	logic        access_ph;
	logic        mapped;
	logic [9:0]  reg_idx;
	logic [31:0] status_word;

	// Register index hit on a word-aligned address
	function automatic logic idx_known(input logic [ARX_ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = addr[ARX_ADDR_W-1:2];
		idx_known = (addr[1:0] == 2'b00) && (idx == ARX_IDX_CTRL0 || idx == ARX_IDX_CTRL1
			|| idx == ARX_IDX_CTRL4 || idx == ARX_IDX_STATUS);
	endfunction : idx_known

	////////////////////////////////////////////////////////////////////////////////
	// Mode-dependent selection and switch control
	always_comb begin
		if (hw_mode) begin
			dec_sel  = {1'b0, decoder_input_select_pins};
			pass_sel = {1'b0, passthrough_select_pins};
			auto_en  = st_r.hw_sw_en;
			force_sw = 1'b0;
		end else begin
			dec_sel  = st_r.ctrl4[ARX_CTRL4_DEC_LO +: 3];
			pass_sel = st_r.ctrl4[ARX_CTRL4_PAS_LO +: 3];
			auto_en  = st_r.ctrl1[ARX_CTRL1_AUTO];
			force_sw = st_r.ctrl0[ARX_CTRL0_FORCE];
		end
		want_ext = force_sw || (auto_en && !pll_locked);
	end

	arx_input_mux u_mux (
		.rx_input_lines (rx_input_lines),
		.dec_sel        (dec_sel),
		.pass_sel       (pass_sel),
		.line_en        (rx_line_bias_en),
		.dec_line       (decoder_data),
		.pass_line      (passthrough_out)
	);

	assign shared_negative_bias_en = |rx_line_bias_en;

	////////////////////////////////////////////////////////////////////////////////
	// Status word and APB phases
	always_comb begin
		status_word                       = 32'h0000_0000;
		status_word[ARX_ST_LOCKED]        = pll_locked;
		status_word[ARX_ST_ON_EXT]        = (st_r.sw == ARX_ON_EXT);
		status_word[ARX_ST_AUTO]          = auto_en;
		status_word[ARX_ST_HW]            = hw_mode;
		status_word[ARX_ST_DEC_LO +: 3]   = dec_sel;
		status_word[ARX_ST_PAS_LO +: 3]   = pass_sel;
		status_word[ARX_ST_BCLK]          = serial_master_mode ? div_bclk : serial_bit_clock_i;
		status_word[ARX_ST_LRCK]          = serial_master_mode ? div_lrck : serial_lr_clock_i;
		setup_ph  = apb_req.psel && !apb_req.penable;
		access_ph = apb_req.psel && apb_req.penable;
		mapped    = idx_known(apb_req.paddr);
		reg_idx   = apb_req.paddr[ARX_ADDR_W-1:2];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;

		if (setup_ph && !apb_req.pwrite) begin
			st_nxt.prdata = 32'h0000_0000;
			if (mapped) begin
				case (reg_idx)
					ARX_IDX_CTRL0: st_nxt.prdata = {24'h000000, st_r.ctrl0};
					ARX_IDX_CTRL1: st_nxt.prdata = {24'h000000, st_r.ctrl1};
					ARX_IDX_CTRL4: st_nxt.prdata = {24'h000000, st_r.ctrl4};
					default:       st_nxt.prdata = status_word;
				endcase
			end
		end
		if (access_ph && apb_req.pwrite && mapped) begin
			case (reg_idx)
				ARX_IDX_CTRL0: st_nxt.ctrl0 = apb_req.pwdata[7:0] & ARX_CTRL0_MASK;
				ARX_IDX_CTRL1: st_nxt.ctrl1 = apb_req.pwdata[7:0] & ARX_CTRL1_MASK;
				ARX_IDX_CTRL4: st_nxt.ctrl4 = apb_req.pwdata[7:0] & ARX_CTRL4_MASK;
				default:       st_nxt.ctrl0 = st_r.ctrl0;
			endcase
		end

		// Hardware-mode enable: first sample primes, later rising edge sets it for good
		st_nxt.ext_prev = external_system_clock;
		st_nxt.primed   = 1'b1;
		if (hw_mode && st_r.primed && !st_r.ext_prev && external_system_clock) begin
			st_nxt.hw_sw_en = 1'b1;
		end

		// Changeover gates the outgoing clock while it is low, then takes the incoming one while it is low
		case (st_r.sw)
			ARX_ON_REC: begin
				st_nxt.mclk = pll_oscillator;
				if (want_ext && !pll_oscillator) begin
					st_nxt.sw   = ARX_GATE_TO_EXT;
					st_nxt.mclk = 1'b0;
				end
			end
			ARX_GATE_TO_EXT: begin
				st_nxt.mclk = 1'b0;
				if (!external_system_clock) begin
					st_nxt.sw = ARX_ON_EXT;
				end
			end
			ARX_ON_EXT: begin
				st_nxt.mclk = external_system_clock;
				if (!want_ext && !external_system_clock) begin
					st_nxt.sw   = ARX_GATE_TO_REC;
					st_nxt.mclk = 1'b0;
				end
			end
			ARX_GATE_TO_REC: begin
				st_nxt.mclk = 1'b0;
				if (!pll_oscillator) begin
					st_nxt.sw = ARX_ON_REC;
				end
			end
			default: begin
				st_nxt.sw   = ARX_ON_REC;
				st_nxt.mclk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r          <= '0;
			st_r.ctrl0    <= ARX_CTRL0_RST;
			st_r.ctrl1    <= ARX_CTRL1_RST;
			st_r.ctrl4    <= ARX_CTRL4_RST;
			st_r.sw       <= ARX_ON_REC;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	arx_serial_div u_div (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.mclk_lvl (st_r.mclk),
		.bclk     (div_bclk),
		.lrck     (div_lrck)
	);

	always_comb begin
		recovered_master_clock = st_r.mclk;
		serial_bit_clock_o     = div_bclk;
		serial_lr_clock_o      = div_lrck;
		serial_bit_clock_oe    = serial_master_mode;
		serial_lr_clock_oe     = serial_master_mode;
		apb_rsp.prdata         = st_r.prdata;
		apb_rsp.pready         = 1'b1;
		apb_rsp.pslverr        = access_ph && !mapped;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_leave_ext;
		st_r.sw == ARX_ON_EXT && !want_ext && !external_system_clock && clk_en;
	endsequence

	sequence s_gated_low;
		st_r.sw == ARX_GATE_TO_REC && !recovered_master_clock;
	endsequence

	sequence s_hop_to_ext;
		st_r.sw == ARX_ON_REC && want_ext && !pll_oscillator && clk_en;
	endsequence

	sequence s_gated_ext;
		st_r.sw == ARX_GATE_TO_EXT && !recovered_master_clock;
	endsequence

	a_sw_dec_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!hw_mode |-> dec_sel == st_r.ctrl4[ARX_CTRL4_DEC_LO +: 3])
		else $error("decoder select does not follow register field");
	a_sw_pass_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!hw_mode |-> pass_sel == st_r.ctrl4[ARX_CTRL4_PAS_LO +: 3])
		else $error("pass-through select does not follow register field");
	a_hw_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hw_mode |-> !dec_sel[2] && !pass_sel[2] && pass_sel[1:0] == passthrough_select_pins)
		else $error("hardware mode selects beyond input three");
	a_hw_dec_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hw_mode |-> dec_sel[1:0] == decoder_input_select_pins)
		else $error("decoder select does not follow select pins");
	a_hw_edge_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && hw_mode && st_r.primed && !st_r.ext_prev && external_system_clock
		|=> st_r.hw_sw_en)
		else $error("rising edge did not enable switching");
	a_soft_no_arm: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !hw_mode && !st_r.hw_sw_en |=> !st_r.hw_sw_en)
		else $error("switching armed outside hardware mode");
	a_hw_en_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_r.hw_sw_en |=> st_r.hw_sw_en)
		else $error("hardware switching enable was cleared");
	a_auto_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!hw_mode && (st_r.ctrl0[ARX_CTRL0_FORCE]
		|| (st_r.ctrl1[ARX_CTRL1_AUTO] && !pll_locked)) |-> want_ext)
		else $error("switch request missing");
	a_ext_drives: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && st_r.sw == ARX_ON_EXT && want_ext
		|=> recovered_master_clock == $past(external_system_clock))
		else $error("external clock not driven on master clock");
	a_hop_to_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_hop_to_ext |=> s_gated_ext)
		else $error("no glitch-free hop toward external clock");
	a_force_hop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !hw_mode && st_r.ctrl0[ARX_CTRL0_FORCE] && st_r.sw == ARX_ON_REC
		&& !pll_oscillator |=> st_r.sw == ARX_GATE_TO_EXT)
		else $error("force bit did not start the changeover");
	a_gate_ext_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && st_r.sw == ARX_GATE_TO_EXT && !external_system_clock
		|=> st_r.sw == ARX_ON_EXT)
		else $error("changeover to external clock stalled");
	a_gate_held_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_r.sw == ARX_GATE_TO_EXT || st_r.sw == ARX_GATE_TO_REC
		|-> !recovered_master_clock)
		else $error("master clock not held low during changeover");
	a_rise_only_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(recovered_master_clock) |-> $past(st_r.sw) == ARX_ON_REC
		|| $past(st_r.sw) == ARX_ON_EXT)
		else $error("master clock edge during changeover");
	a_stay_rec: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && st_r.sw == ARX_ON_REC && !want_ext
		|=> st_r.sw == ARX_ON_REC)
		else $error("left recovered clock without a request");
	a_rec_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && st_r.sw == ARX_ON_REC
		|=> recovered_master_clock == $past(pll_oscillator))
		else $error("master clock does not follow the oscillator");
	a_return_rec: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_leave_ext |=> s_gated_low)
		else $error("no glitch-free return toward recovered clock");
	a_gate_rec_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && st_r.sw == ARX_GATE_TO_REC && !pll_oscillator
		|=> st_r.sw == ARX_ON_REC)
		else $error("changeover to recovered clock stalled");
	a_serial_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
		serial_master_mode |-> serial_bit_clock_oe && serial_lr_clock_oe
		&& serial_bit_clock_o == div_bclk)
		else $error("serial clocks not driven in master mode");

endmodule : arx_clk_select

// >>> hw/arx_input_mux.sv
// Purpose: Eight-way decoder and pass-through input selection with line enables
// Assumes: Select values already limited by the caller for hardware mode
// Notes:   Purely combinational; the pass-through copy is not retimed
`timescale 1ns/1ps
module arx_input_mux (
	input  wire logic [7:0] rx_input_lines,
	input  wire logic [2:0] dec_sel,
	input  wire logic [2:0] pass_sel,
	output logic      [7:0] line_en,
	output logic            dec_line,
	output logic            pass_line
);
	import arx_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Both selectors act independently; unchosen lines stay floating
	always_comb begin
		line_en   = arx_onehot(dec_sel) | arx_onehot(pass_sel);
		dec_line  = rx_input_lines[dec_sel];
		pass_line = rx_input_lines[pass_sel];
		// Checks in the same process, so they never see a half-updated selection
		a_line_unused_hiz: assert (
			(line_en & ~(arx_onehot(dec_sel) | arx_onehot(pass_sel))) == 8'h00
			&& line_en[dec_sel] && line_en[pass_sel])
			else $error("line enable does not match selections");
		a_pass_raw_copy: assert (pass_line == rx_input_lines[pass_sel])
			else $error("pass-through is not a direct copy");
	end

endmodule : arx_input_mux

// >>> hw/arx_serial_div.sv
// Purpose: Derives bit clock and left/right clock from the switched master clock
// Assumes: Master clock level is sampled at clk_sys, below half its rate
// Notes:   Bit clock is master clock over 4, left/right clock over 256
`timescale 1ns/1ps
module arx_serial_div (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic clk_en,
	input  wire logic mclk_lvl,
	output logic      bclk,
	output logic      lrck
);
	import arx_pkg::*;

	arx_div_st_t st_r;
	arx_div_st_t st_nxt;
	logic        rise;

	////////////////////////////////////////////////////////////////////////////////
	// Count master clock rising edges
	always_comb begin
		st_nxt           = st_r;
		rise             = mclk_lvl && !st_r.mclk_prev;
		st_nxt.mclk_prev = mclk_lvl;
		if (rise) begin
			st_nxt.cnt  = st_r.cnt + 8'h01;
			st_nxt.bclk = st_nxt.cnt[ARX_BCLK_BIT];
			st_nxt.lrck = st_nxt.cnt[ARX_LRCK_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign bclk = st_r.bclk;
	assign lrck = st_r.lrck;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_bclk_div_four: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && rise && st_r.cnt[1:0] == 2'b01 |=> bclk)
		else $error("bit clock did not rise after two master edges");
	a_lrck_div_256: assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && rise && st_r.cnt == 8'hFF |=> !lrck && st_r.cnt == 8'h00)
		else $error("left/right clock did not wrap after 256 master edges");

endmodule : arx_serial_div

// >>> shared/arx_pkg.sv
// Purpose: Shared constants and types for the receiver input select and clock switch block
// Assumes: APB register access with 32-bit data, one clock domain
// Notes:   Register indices are multiplied by four to form byte addresses
package arx_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int          ARX_ADDR_W       = 12;
	localparam logic [9:0]  ARX_IDX_CTRL0    = 10'h000;
	localparam logic [9:0]  ARX_IDX_CTRL1    = 10'h001;
	localparam logic [9:0]  ARX_IDX_CTRL4    = 10'h004;
	localparam logic [9:0]  ARX_IDX_STATUS   = 10'h008;
	localparam logic [7:0]  ARX_CTRL0_RST    = 8'h00;
	localparam logic [7:0]  ARX_CTRL1_RST    = 8'h00;
	localparam logic [7:0]  ARX_CTRL4_RST    = 8'h00;
	localparam int          ARX_CTRL0_FORCE  = 0;
	localparam int          ARX_CTRL1_AUTO   = 0;
	localparam int          ARX_CTRL4_DEC_LO = 3;
	localparam int          ARX_CTRL4_PAS_LO = 0;
	localparam logic [7:0]  ARX_CTRL0_MASK   = 8'h01;
	localparam logic [7:0]  ARX_CTRL1_MASK   = 8'h01;
	localparam logic [7:0]  ARX_CTRL4_MASK   = 8'h3F;

	////////////////////////////////////////////////////////////////////////////////
	// Status word positions
	localparam int ARX_ST_LOCKED  = 0;
	localparam int ARX_ST_ON_EXT  = 1;
	localparam int ARX_ST_AUTO    = 2;
	localparam int ARX_ST_HW      = 3;
	localparam int ARX_ST_DEC_LO  = 4;
	localparam int ARX_ST_PAS_LO  = 8;
	localparam int ARX_ST_BCLK    = 12;
	localparam int ARX_ST_LRCK    = 13;

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock division: counter width and the counter bit that drives each clock
	localparam int          ARX_CNT_W     = 8;
	localparam int          ARX_BCLK_BIT  = 1;
	localparam int          ARX_LRCK_BIT  = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		ARX_ON_REC      = 2'b00,
		ARX_GATE_TO_EXT = 2'b01,
		ARX_ON_EXT      = 2'b11,
		ARX_GATE_TO_REC = 2'b10
	} arx_sw_state_t;

	typedef struct packed {
		logic                  psel;
		logic                  penable;
		logic                  pwrite;
		logic [ARX_ADDR_W-1:0] paddr;
		logic [31:0]           pwdata;
	} arx_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} arx_apb_rsp_t;

	typedef struct packed {
		logic [7:0]    ctrl0;
		logic [7:0]    ctrl1;
		logic [7:0]    ctrl4;
		logic [31:0]   prdata;
		arx_sw_state_t sw;
		logic          ext_prev;
		logic          primed;
		logic          hw_sw_en;
		logic          mclk;
	} arx_top_st_t;

	typedef struct packed {
		logic                 mclk_prev;
		logic [ARX_CNT_W-1:0] cnt;
		logic                 bclk;
		logic                 lrck;
	} arx_div_st_t;

	// One-hot decode of a three-bit input number
	function automatic logic [7:0] arx_onehot(input logic [2:0] sel);
		arx_onehot = 8'h01 << sel;
	endfunction : arx_onehot

endpackage : arx_pkg

// >>> sim/arx_clk_select_tb.sv
// Purpose: Self-checking bench for input selection and master clock switching
// Assumes: APB slave answers with zero wait states but is waited for anyway
// Notes:   Clock rates are judged by counting rising edges over a fixed window
`timescale 1ns/1ps
module arx_clk_select_tb;
	import arx_pkg::*;
	logic         clk_sys = 1'b0;
	logic         rst_n = 1'b0;
	logic         clk_en = 1'b1;
	arx_apb_req_t apb_req = '0;
	arx_apb_rsp_t apb_rsp;
	logic         hw_mode = 1'b0;
	logic [1:0]   dec_pins = 2'h0;
	logic [1:0]   pass_pins = 2'h0;
	logic [7:0]   rx_input_lines = 8'h00;
	logic [7:0]   rx_line_bias_en;
	logic         shared_negative_bias_en, decoder_data, passthrough_out;
	logic         ext_clk, osc, pll_locked = 1'b0, serial_master_mode = 1'b0, ext_run = 1'b0;
	logic         recovered_master_clock, bclk_i, bclk_o, bclk_oe, lrck_i, lrck_o, lrck_oe;
	logic [2:0]   c_prev = 3'h0;
	int           errors = 0, samples_checked = 0, n_m = 0, n_b = 0, n_l = 0, run = 8;

	always #5 clk_sys = ~clk_sys;
	assign bclk_i = bclk_oe ? bclk_o : 1'b0;
	assign lrck_i = lrck_oe ? lrck_o : 1'b0;

	arx_far_model i_far (.clk_sys(clk_sys), .ext_run(ext_run),
		.external_system_clock(ext_clk), .pll_oscillator(osc));

	arx_clk_select i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .hw_mode(hw_mode),
		.decoder_input_select_pins(dec_pins), .passthrough_select_pins(pass_pins),
		.rx_input_lines(rx_input_lines), .rx_line_bias_en(rx_line_bias_en),
		.shared_negative_bias_en(shared_negative_bias_en), .decoder_data(decoder_data),
		.passthrough_out(passthrough_out), .external_system_clock(ext_clk),
		.pll_oscillator(osc), .pll_locked(pll_locked), .serial_master_mode(serial_master_mode),
		.recovered_master_clock(recovered_master_clock), .serial_bit_clock_i(bclk_i),
		.serial_bit_clock_o(bclk_o), .serial_bit_clock_oe(bclk_oe), .serial_lr_clock_i(lrck_i),
		.serial_lr_clock_o(lrck_o), .serial_lr_clock_oe(lrck_oe));

	task automatic finish_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////////////
	// Edge counters and minimum pulse width on the master clock
	always @(posedge clk_sys) begin
		if (recovered_master_clock && !c_prev[0]) n_m++;
		if (bclk_o && !c_prev[1]) n_b++;
		if (lrck_o && !c_prev[2]) n_l++;
		if (recovered_master_clock !== c_prev[0]) begin
			if (rst_n) chk(32'(run >= 2), 1);
			run = 0;
		end
		run++;
		c_prev = {lrck_o, bclk_o, recovered_master_clock};
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB master
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_sys);
		apb_req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (apb_rsp.pready !== 1'b1);
		// The slave answers in its first access cycle
		chk(n, 1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdx(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
			input logic eerr);
		logic [31:0] d;
		logic        e;
		xfer(1'b0, a, 32'h0, d, e);
		chk(d & m, exp);
		chk(32'(e), 32'(eerr));
	endtask : rdx

	function automatic logic near(input int g, input int e, input int t);
		return g >= e - t && g <= e + t;
	endfunction : near

	// Rising edges over 4096 cycles: master clock, bit clock /4, lr clock /256
	task automatic rate(input int em);
		int m0, b0, l0;
		repeat (64) @(posedge clk_sys);
		m0 = n_m;
		b0 = n_b;
		l0 = n_l;
		repeat (4096) @(posedge clk_sys);
		chk(32'(near(n_m - m0, em, 2)), 1);
		chk(32'(near(n_b - b0, em / 4, 2)), 1);
		chk(32'(near(n_l - l0, em / 256, 1)), 1);
	endtask : rate

	task automatic rst();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
	endtask : rst

	initial begin
		#500_000;
		errors++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdx(12'h000, 32'hFFFF_FFFF, 0, 0);
		rdx(12'h004, 32'hFFFF_FFFF, 0, 0);
		rdx(12'h010, 32'hFFFF_FFFF, 0, 0);
		rdx(12'h0FC, 32'hFFFF_FFFF, 0, 1);
		rdx(12'h002, 32'hFFFF_FFFF, 0, 1);
		wr(12'h010, 32'hFFFF_FFFF);
		rdx(12'h010, 32'hFFFF_FFFF, 32'h3F, 0);
		for (int d = 0; d < 8; d++) begin
			int p;
			p = (3 * d) & 7;
			wr(12'h010, 32'(d * 8 + p));
			for (int k = 0; k < 2; k++) begin
				@(posedge clk_sys);
				rx_input_lines <= k ? 8'h5A : 8'hA5;
				#1;
				chk(decoder_data, rx_input_lines[d]);
				chk(passthrough_out, rx_input_lines[p]);
			end
			chk(rx_line_bias_en, (8'h01 << d) | (8'h01 << p));
			chk(shared_negative_bias_en, 1);
		end
		// Writes are dropped while the clock enable is low
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(12'h010, 32'h0000_0000);
		repeat (4) @(posedge clk_sys);
		clk_en <= 1'b1;
		rdx(12'h010, 32'hFFFF_FFFF, 32'h0000_003D, 0);
		@(posedge clk_sys);
		hw_mode <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			dec_pins <= 2'(i);
			pass_pins <= 2'(3 - i);
			rx_input_lines <= 8'h96;
			#1;
			chk(decoder_data, rx_input_lines[i]);
			chk(passthrough_out, rx_input_lines[3 - i]);
			chk(rx_line_bias_en, (8'h01 << i) | (8'h01 << (3 - i)));
		end
		@(posedge clk_sys);
		hw_mode <= 1'b0;
		ext_run <= 1'b1;
		pll_locked <= 1'b1;
		serial_master_mode <= 1'b1;
		wr(12'h004, 32'h1);
		rate(682);
		rdx(12'h020, 32'h7, 32'h5, 0);
		chk(bclk_oe & lrck_oe, 1);
		pll_locked <= 1'b0;
		rate(512);
		rdx(12'h020, 32'h7, 32'h6, 0);
		pll_locked <= 1'b1;
		rate(682);
		rdx(12'h020, 32'h7, 32'h5, 0);
		wr(12'h004, 32'h0);
		pll_locked <= 1'b0;
		rate(682);
		rdx(12'h020, 32'h7, 32'h0, 0);
		wr(12'h000, 32'h1);
		pll_locked <= 1'b1;
		rate(512);
		rdx(12'h020, 32'h7, 32'h3, 0);
		wr(12'h000, 32'h0);
		serial_master_mode <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(bclk_oe | lrck_oe, 0);
		rdx(12'h020, 32'h0000_3000, 32'h0000_0000, 0);
		@(posedge clk_sys);
		hw_mode <= 1'b1;
		ext_run <= 1'b0;
		pll_locked <= 1'b0;
		rst();
		rate(682);
		rdx(12'h020, 32'hF, 32'h8, 0);
		ext_run <= 1'b1;
		rate(512);
		rdx(12'h020, 32'hF, 32'hE, 0);
		ext_run <= 1'b0;
		repeat (32) @(posedge clk_sys);
		rdx(12'h020, 32'h4, 32'h4, 0);
		rst();
		rdx(12'h020, 32'h4, 32'h0, 0);
		finish_test();
	end
endmodule : arx_clk_select_tb

// >>> sim/arx_far_model.sv
// Purpose: Far side of the block: external system clock source and idle pll oscillator
// Assumes: Both clocks are made from clk_sys, well below half its rate
// Notes:   External clock period 8 clk_sys cycles, oscillator period 6
`timescale 1ns/1ps
module arx_far_model (
	input  wire logic clk_sys,
	input  wire logic ext_run,
	output logic      external_system_clock,
	output logic      pll_oscillator
);
	int ce = 0;
	int co = 0;

	initial begin
		external_system_clock = 1'b0;
		pll_oscillator = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator keeps running whether locked or not
	always @(posedge clk_sys) begin
		co <= (co == 2) ? 0 : co + 1;
		if (co == 2) pll_oscillator <= !pll_oscillator;
		if (!ext_run) begin
			ce <= 0;
			external_system_clock <= 1'b0;
		end else begin
			ce <= (ce == 3) ? 0 : ce + 1;
			if (ce == 3) external_system_clock <= !external_system_clock;
		end
	end
endmodule : arx_far_model
